// >>> src/wbwc_pkg.sv
// Function
// - bit 5 picks time-out or window watchdog
// - bit 6 low stop-mode watchdog disable
// - bit 4 starts watchdog on bus wake
// - period codes map 10 ms to 10000 ms
// - reserved bits read zero, ignore writes
// - watchdog resets 0x14, restart x0xx 0100
// - mode field low bits, top bit selective wake
// - hardware changes selective wake bit only on soft reset or late load
// - sleep without error turns normal to wake
// - receive-only: sleep forces wake, stop keeps
// - wake or off unchanged on low power
// - fail-safe writes mode 0000 0x01
// - development mode resets mode to 011
// - mode resets zero, restart 0000 0xyy
// - bit 6 enables cyclic timer wake
// - bit 2 high stop-mode watchdog disable
// - stop to normal clears high disable
// - wake register resets zero, restart keeps bit 6
// - write returns previously programmed contents
package wbwc_pkg;
    localparam logic [6:0] WBWC_ADDR_WDOG = 7'h03;
    localparam logic [6:0] WBWC_ADDR_XCVR = 7'h04;
    localparam logic [6:0] WBWC_ADDR_WAKE = 7'h06;
    localparam logic [7:0] WBWC_WDOG_POR = 8'h14;
    localparam logic [7:0] WBWC_WDOG_MASK = 8'hF7;
    localparam logic [7:0] WBWC_WDOG_RST_KEEP = 8'hB0;
    localparam logic [7:0] WBWC_WDOG_RST_FIX = 8'h04;
    localparam logic [7:0] WBWC_XCVR_POR = 8'h00;
    localparam logic [7:0] WBWC_XCVR_MASK = 8'h07;
    localparam logic [7:0] WBWC_WAKE_POR = 8'h00;
    localparam logic [7:0] WBWC_WAKE_MASK = 8'h44;
    localparam logic [7:0] WBWC_WAKE_RST_KEEP = 8'h40;
    localparam int WBWC_WD_STOP_LO_BIT = 6;
    localparam int WBWC_WD_TYPE_BIT = 5;
    localparam int WBWC_WD_BUSWAKE_BIT = 4;
    localparam int WBWC_XCVR_SWK_BIT = 2;
    localparam int WBWC_WAKE_CYCLIC_BIT = 6;
    localparam int WBWC_WAKE_STOP_HI_BIT = 2;
    localparam logic [1:0] WBWC_XCVR_OFF = 2'h0;
    localparam logic [1:0] WBWC_XCVR_WAKE = 2'h1;
    localparam logic [1:0] WBWC_XCVR_RXONLY = 2'h2;
    localparam logic [1:0] WBWC_XCVR_NORMAL = 2'h3;
    localparam logic [2:0] WBWC_XCVR_DEV_POR = 3'h3;
    localparam logic [1:0] WBWC_DEV_LOAD_CNT = 2'h2;
    localparam int WBWC_SPI_FRAME_BITS = 16;
    localparam logic [13:0] WBWC_PER0_MS = 14'd10;
    localparam logic [13:0] WBWC_PER1_MS = 14'd20;
    localparam logic [13:0] WBWC_PER2_MS = 14'd50;
    localparam logic [13:0] WBWC_PER3_MS = 14'd100;
    localparam logic [13:0] WBWC_PER4_MS = 14'd200;
    localparam logic [13:0] WBWC_PER5_MS = 14'd500;
    localparam logic [13:0] WBWC_PER6_MS = 14'd1000;
    localparam logic [13:0] WBWC_PER7_MS = 14'd10000;

    typedef struct packed {
        logic soft_reset;
        logic restart;
        logic enter_sleep;
        logic enter_stop;
        logic stop_to_normal;
        logic enter_failsafe;
    } wbwc_mode_evt_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [6:0] addr;
        logic [7:0] data;
    } wbwc_frame_t;

    typedef struct packed {
        logic stop_wdog_disable_hi;
        logic stop_wdog_disable_lo;
        logic wdog_type_select;
        logic wdog_start_on_bus_wake;
        logic [2:0] wdog_period_select;
        logic [13:0] wdog_period_ms;
        logic [2:0] xcvr_mode;
        logic cyclic_wake_enable;
    } wbwc_cfg_t;
endpackage

// >>> src/wbwc_spi_slave.sv
`timescale 1ns/1ps
module wbwc_spi_slave
    import wbwc_pkg::*;
#(
    parameter int FRAME_BITS = WBWC_SPI_FRAME_BITS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // serial pins
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic i_mosi,
    output logic o_miso,
    // register side
    output logic o_rd_req,
    output logic [6:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    output wbwc_frame_t o_frame
);
    logic [2:0] sclk_q;
    logic [2:0] cs_q;
    logic [1:0] mosi_q;
    logic [4:0] cnt_q, cnt_d;
    logic [15:0] shift_q, shift_d;
    logic [7:0] tx_q, tx_d;
    logic miso_q, miso_d;
    wbwc_frame_t frame_q, frame_d;
    logic rise, fall, cs_end;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sclk_q <= 3'h0;
            cs_q <= 3'h7;
            mosi_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], i_sclk};
            cs_q <= {cs_q[1:0], i_cs_b};
            mosi_q <= {mosi_q[0], i_mosi};
        end
    end

    assign rise = sclk_q[1] & ~sclk_q[2] & ~cs_q[1];
    assign fall = ~sclk_q[1] & sclk_q[2] & ~cs_q[1];
    assign cs_end = cs_q[1] & ~cs_q[2];
    assign o_rd_req = rise && (cnt_q == 5'd7);
    assign o_rd_addr = {shift_q[5:0], mosi_q[1]};

    always_comb begin
        cnt_d = cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        miso_d = miso_q;
        frame_d = '0;
        if (cs_q[1]) begin
            cnt_d = 5'd0;
            miso_d = 1'b0;
        end
        if (rise && cnt_q < 5'd31) begin
            shift_d = {shift_q[14:0], mosi_q[1]};
            cnt_d = cnt_q + 5'd1;
        end
        // old contents are latched before any write lands
        if (o_rd_req) begin
            tx_d = i_rd_data;
        end
        if (fall && cnt_q >= 5'd8 && cnt_q < 5'(FRAME_BITS)) begin
            miso_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
        end
        // frames of any other length are dropped
        if (cs_end && cnt_q == 5'(FRAME_BITS)) begin
            frame_d.valid = 1'b1;
            frame_d.write = shift_q[15];
            frame_d.addr = shift_q[14:8];
            frame_d.data = shift_q[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cnt_q <= 5'd0;
            shift_q <= 16'h0000;
            tx_q <= 8'h00;
            miso_q <= 1'b0;
            frame_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            miso_q <= miso_d;
            frame_q <= frame_d;
        end
    end

    assign o_miso = miso_q;
    assign o_frame = frame_q;
endmodule

// >>> src/wbwc_regs.sv
`timescale 1ns/1ps
module wbwc_regs
    import wbwc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // serial control port
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic i_mosi,
    output logic o_miso,
    // chip mode events and status
    input wire wbwc_mode_evt_t i_mode_evt,
    input wire logic i_system_error_flag,
    input wire logic [1:0] i_restart_xcvr_lo,
    input wire logic i_dev_mode_pin,
    // decoded configuration
    output wbwc_cfg_t o_cfg,
    output logic o_wdog_parity_ok
);
    logic [7:0] wdog_q, wdog_d;
    logic [7:0] xcvr_q, xcvr_d;
    logic [7:0] wake_q, wake_d;
    wbwc_cfg_t cfg_q, cfg_d;
    logic parity_q, parity_d;
    logic dev_s1_q, dev_s2_q;
    logic [1:0] por_cnt_q, por_cnt_d;
    logic dev_load;
    logic rd_req;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    wbwc_frame_t frame;
    logic wr_wdog, wr_xcvr, wr_wake;
    logic hw_quiet;

    function automatic logic [13:0] wbwc_period_ms(input logic [2:0] sel);
        logic [13:0] ms;
        ms = WBWC_PER0_MS;
        case (sel)
            3'h1: ms = WBWC_PER1_MS;
            3'h2: ms = WBWC_PER2_MS;
            3'h3: ms = WBWC_PER3_MS;
            3'h4: ms = WBWC_PER4_MS;
            3'h5: ms = WBWC_PER5_MS;
            3'h6: ms = WBWC_PER6_MS;
            3'h7: ms = WBWC_PER7_MS;
            default: ms = WBWC_PER0_MS;
        endcase
        return ms;
    endfunction

    wbwc_spi_slave u_spi (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_sclk(i_sclk),
        .i_cs_b(i_cs_b),
        .i_mosi(i_mosi),
        .o_miso(o_miso),
        .o_rd_req(rd_req),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .o_frame(frame)
    );

    // unmapped addresses read as zero
    always_comb begin
        case (rd_addr)
            WBWC_ADDR_WDOG: rd_data = wdog_q & WBWC_WDOG_MASK;
            WBWC_ADDR_XCVR: rd_data = xcvr_q & WBWC_XCVR_MASK;
            WBWC_ADDR_WAKE: rd_data = wake_q & WBWC_WAKE_MASK;
            default: rd_data = 8'h00;
        endcase
    end

    assign wr_wdog = frame.valid && frame.write && frame.addr == WBWC_ADDR_WDOG;
    assign wr_xcvr = frame.valid && frame.write && frame.addr == WBWC_ADDR_XCVR;
    assign wr_wake = frame.valid && frame.write && frame.addr == WBWC_ADDR_WAKE;

    // strap is sampled only after the sync chain has settled
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            dev_s1_q <= 1'b0;
            dev_s2_q <= 1'b0;
        end else begin
            dev_s1_q <= i_dev_mode_pin;
            dev_s2_q <= dev_s1_q;
        end
    end

    always_comb begin
        por_cnt_d = por_cnt_q;
        if (por_cnt_q != 2'h3) begin
            por_cnt_d = por_cnt_q + 2'h1;
        end
    end

    assign dev_load = (por_cnt_q == WBWC_DEV_LOAD_CNT) && dev_s2_q;
    assign hw_quiet = !(i_mode_evt.soft_reset || i_mode_evt.restart
                        || i_mode_evt.enter_failsafe || dev_load);

    // hardware updates come after host writes so they win the same cycle
    always_comb begin
        wdog_d = wdog_q;
        xcvr_d = xcvr_q;
        wake_d = wake_q;
        if (wr_wdog) begin
            wdog_d = frame.data & WBWC_WDOG_MASK;
        end
        if (wr_xcvr) begin
            xcvr_d = frame.data & WBWC_XCVR_MASK;
        end
        if (wr_wake) begin
            wake_d = frame.data & WBWC_WAKE_MASK;
        end
        if (i_mode_evt.enter_sleep) begin
            if (xcvr_q[1:0] == WBWC_XCVR_NORMAL && !i_system_error_flag) begin
                xcvr_d = {xcvr_q[7:2], WBWC_XCVR_WAKE};
            end else if (xcvr_q[1:0] == WBWC_XCVR_RXONLY) begin
                xcvr_d = {xcvr_q[7:2], WBWC_XCVR_WAKE};
            end
        end
        // stop entry leaves the field alone; receive-only stays set
        if (i_mode_evt.stop_to_normal) begin
            wake_d[WBWC_WAKE_STOP_HI_BIT] = 1'b0;
        end
        if (i_mode_evt.enter_failsafe) begin
            xcvr_d = {5'h00, xcvr_q[WBWC_XCVR_SWK_BIT], WBWC_XCVR_WAKE};
        end
        if (i_mode_evt.restart) begin
            wdog_d = (wdog_q & WBWC_WDOG_RST_KEEP) | WBWC_WDOG_RST_FIX;
            xcvr_d = {5'h00, xcvr_q[WBWC_XCVR_SWK_BIT], i_restart_xcvr_lo};
            wake_d = wake_q & WBWC_WAKE_RST_KEEP;
        end
        if (i_mode_evt.soft_reset) begin
            wdog_d = WBWC_WDOG_POR;
            wake_d = WBWC_WAKE_POR;
            xcvr_d = dev_s2_q ? {5'h00, WBWC_XCVR_DEV_POR} : WBWC_XCVR_POR;
        end
        // late load of the development-mode value after power-on
        if (dev_load) begin
            xcvr_d = {5'h00, WBWC_XCVR_DEV_POR};
        end
    end

    always_comb begin
        cfg_d.stop_wdog_disable_hi = wake_d[WBWC_WAKE_STOP_HI_BIT];
        cfg_d.stop_wdog_disable_lo = wdog_d[WBWC_WD_STOP_LO_BIT];
        cfg_d.wdog_type_select = wdog_d[WBWC_WD_TYPE_BIT];
        cfg_d.wdog_start_on_bus_wake = wdog_d[WBWC_WD_BUSWAKE_BIT];
        cfg_d.wdog_period_select = wdog_d[2:0];
        cfg_d.wdog_period_ms = wbwc_period_ms(wdog_d[2:0]);
        cfg_d.xcvr_mode = xcvr_d[2:0];
        cfg_d.cyclic_wake_enable = wake_d[WBWC_WAKE_CYCLIC_BIT];
        // host is expected to keep parity even; flagged, not enforced
        parity_d = ~^wdog_d;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wdog_q <= WBWC_WDOG_POR;
            xcvr_q <= WBWC_XCVR_POR;
            wake_q <= WBWC_WAKE_POR;
            cfg_q <= '0;
            parity_q <= 1'b1;
            por_cnt_q <= 2'h0;
        end else begin
            wdog_q <= wdog_d;
            xcvr_q <= xcvr_d;
            wake_q <= wake_d;
            cfg_q <= cfg_d;
            parity_q <= parity_d;
            por_cnt_q <= por_cnt_d;
        end
    end

    assign o_cfg = cfg_q;
    assign o_wdog_parity_ok = parity_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    reserved_read_a: assert property (
        rd_req |-> (rd_addr == WBWC_ADDR_WDOG && (rd_data & ~WBWC_WDOG_MASK) == 8'h00)
            || (rd_addr == WBWC_ADDR_XCVR && (rd_data & ~WBWC_XCVR_MASK) == 8'h00)
            || (rd_addr == WBWC_ADDR_WAKE && (rd_data & ~WBWC_WAKE_MASK) == 8'h00)
            || rd_data == 8'h00
    ) else $error("reserved bits read nonzero");

    wdog_por_a: assert property (
        i_mode_evt.soft_reset |=> wdog_q == 8'h14 ##1 o_cfg.wdog_period_ms == 14'd200
    ) else $error("watchdog soft reset value wrong");

    dev_late_a: assert property (
        dev_load |=> xcvr_q == 8'h03 && o_cfg.xcvr_mode == 3'h3
    ) else $error("development late load value wrong");

    wdog_restart_a: assert property (
        i_mode_evt.restart && !i_mode_evt.soft_reset
            |=> wdog_q == (($past(wdog_q) & 8'hB0) | 8'h04)
    ) else $error("watchdog restart value wrong");

    sleep_wake_a: assert property (
        i_mode_evt.enter_sleep && !i_system_error_flag && xcvr_q[1:0] == 2'h3 && hw_quiet
            |=> xcvr_q[1:0] == 2'h1 ##1 o_cfg.xcvr_mode[1:0] == 2'h1
    ) else $error("sleep entry did not select wake capable");

    rxonly_sleep_a: assert property (
        i_mode_evt.enter_sleep && xcvr_q[1:0] == 2'h2 && hw_quiet |=> xcvr_q[1:0] == 2'h1
    ) else $error("receive-only not forced to wake on sleep");

    swk_hold_a: assert property (
        !wr_xcvr && !i_mode_evt.soft_reset && !dev_load |=> $stable(xcvr_q[2])
    ) else $error("selective wake bit changed by hardware");

    lowpower_keep_a: assert property (
        (i_mode_evt.enter_sleep || i_mode_evt.enter_stop) && !xcvr_q[1] && hw_quiet
            && !wr_xcvr |=> $stable(xcvr_q)
    ) else $error("wake or off mode altered on low power entry");

    failsafe_a: assert property (
        i_mode_evt.enter_failsafe && !i_mode_evt.restart && !i_mode_evt.soft_reset
            && !dev_load |=> xcvr_q == {5'h00, $past(xcvr_q[2]), 2'h1}
    ) else $error("fail-safe transceiver value wrong");

    dev_por_a: assert property (
        i_mode_evt.soft_reset && dev_s2_q |=> xcvr_q == 8'h03
    ) else $error("development reset value wrong");

    stop_normal_a: assert property (
        i_mode_evt.stop_to_normal |=> !wake_q[2] ##1 !o_cfg.stop_wdog_disable_hi
    ) else $error("high stop disable not cleared");

    wake_restart_a: assert property (
        i_mode_evt.restart && !i_mode_evt.soft_reset
            |=> wake_q == {1'b0, $past(wake_q[6]), 6'h00}
    ) else $error("wake register restart value wrong");

    period_map_a: assert property (
        wr_wdog && frame.data[2:0] == 3'h7 && hw_quiet
            |=> ##1 o_cfg.wdog_period_ms == 14'd10000 && o_cfg.wdog_period_select == 3'h7
    ) else $error("period code 111 not 10000 ms");
endmodule

// >>> verification/wbwc_spi_host.sv
`timescale 1ns/1ps
module wbwc_spi_host (
    // clock
    input wire logic i_clk,
    // serial pins
    output logic o_sclk,
    output logic o_cs_b,
    output logic o_mosi,
    input wire logic i_miso
);
    // half period well above the three-cycle minimum, leaves miso settled
    localparam int HALF = 6;

    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_mosi = 1'b0;
    end

    // sclk stands low between frames; mosi flips once released
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [15:0] f;
        f = {wr, a, wd};
        rd = 8'h00;
        @(negedge i_clk);
        o_cs_b <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_mosi <= f[i];
            repeat (HALF) @(negedge i_clk);
            o_sclk <= 1'b1;
            if (i < 8) begin
                rd[i] = i_miso;
            end
            repeat (HALF) @(negedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (HALF) @(negedge i_clk);
        o_cs_b <= 1'b1;
        o_mosi <= ~f[0];
        repeat (8) @(negedge i_clk);
    endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb
    import wbwc_pkg::*;
;
    logic i_clk;
    logic i_rst_b;
    logic sclk;
    logic cs_b;
    logic mosi;
    logic miso;
    wbwc_mode_evt_t evt;
    logic err;
    logic [1:0] rlo;
    logic strap;
    wbwc_cfg_t cfg;
    logic pok;
    int failures;
    int checked;
    logic [7:0] m_wd;
    logic [7:0] m_xm;
    logic [7:0] m_wk;
    logic [13:0] per_tbl [8] = '{14'h000A, 14'h0014, 14'h0032, 14'h0064,
                                 14'h00C8, 14'h01F4, 14'h03E8, 14'h2710};

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    wbwc_spi_host host_u (.i_clk(i_clk), .o_sclk(sclk), .o_cs_b(cs_b), .o_mosi(mosi),
                          .i_miso(miso));

    wbwc_regs dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_cs_b(cs_b),
                     .i_mosi(mosi), .o_miso(miso), .i_mode_evt(evt),
                     .i_system_error_flag(err), .i_restart_xcvr_lo(rlo),
                     .i_dev_mode_pin(strap), .o_cfg(cfg), .o_wdog_parity_ok(pok));

    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_cfg();
        wbwc_cfg_t e;
        e = {m_wk[2], m_wd[6], m_wd[5], m_wd[4], m_wd[2:0], per_tbl[m_wd[2:0]],
             m_xm[2:0], m_wk[6]};
        checked++;
        if (cfg !== e || pok !== ~^m_wd) begin
            failures++;
            $display("Error cfg expected %h/%b seen %h/%b", e, ~^m_wd, cfg, pok);
        end
    endtask

    function automatic logic [7:0] m_rd(input logic [6:0] a);
        case (a)
            WBWC_ADDR_WDOG: return m_wd;
            WBWC_ADDR_XCVR: return m_xm;
            WBWC_ADDR_WAKE: return m_wk;
            default: return 8'h00;
        endcase
    endfunction

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        host_u.xfer(1'b1, a, d, r);
        chk_byte("write echo", m_rd(a), r);
        if (a == WBWC_ADDR_WDOG) m_wd = d & WBWC_WDOG_MASK;
        if (a == WBWC_ADDR_XCVR) m_xm = d & WBWC_XCVR_MASK;
        if (a == WBWC_ADDR_WAKE) m_wk = d & WBWC_WAKE_MASK;
        chk_cfg();
    endtask

    task automatic rd(input logic [6:0] a);
        logic [7:0] r;
        host_u.xfer(1'b0, a, 8'h00, r);
        chk_byte("register read", m_rd(a), r);
    endtask

    // one-cycle event pulse, then long enough for the registers and cfg to settle
    task automatic pulse(input logic [5:0] e);
        @(negedge i_clk);
        evt <= e;
        @(negedge i_clk);
        evt <= '0;
        repeat (6) @(negedge i_clk);
        chk_cfg();
    endtask

    initial begin
        logic [7:0] d;
        logic [6:0] a;
        evt = '0;
        err = 1'b0;
        rlo = 2'h0;
        strap = 1'b0;
        i_rst_b = 1'b0;
        failures = 0;
        checked = 0;
        void'($urandom(32'h113BD09C));
        m_wd = WBWC_WDOG_POR;
        m_xm = WBWC_XCVR_POR;
        m_wk = WBWC_WAKE_POR;
        repeat (8) @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (6) @(negedge i_clk);
        chk_cfg();
        for (int i = 0; i < 8; i++) rd(7'(i));
        for (int i = 0; i < 8; i++) begin
            d = {1'b0, 3'($urandom), 1'b0, 3'(i)};
            d[7] = ^d[6:0];
            wr(WBWC_ADDR_WDOG, d);
        end
        for (int i = 0; i < 16; i++) begin
            a = 7'($urandom_range(3, 6));
            d = 8'($urandom);
            wr(a, d);
            rd(a);
        end
        // sleep with both error levels, then stop, for every mode code
        for (int i = 0; i < 24; i++) begin
            err = i[3];
            wr(WBWC_ADDR_XCVR, 8'(i % 8));
            if (i < 16) begin
                if (m_xm[1:0] == 2'h2 || (m_xm[1:0] == 2'h3 && !err)) m_xm[1:0] = 2'h1;
                pulse(6'h08);
            end else begin
                pulse(6'h04);
            end
            rd(WBWC_ADDR_XCVR);
        end
        for (int i = 0; i < 2; i++) begin
            wr(WBWC_ADDR_XCVR, i ? 8'h02 : 8'h07);
            m_xm = {5'h00, m_xm[2], 2'h1};
            pulse(6'h01);
            rd(WBWC_ADDR_XCVR);
        end
        wr(WBWC_ADDR_WAKE, 8'h44);
        m_wk[2] = 1'b0;
        pulse(6'h02);
        rd(WBWC_ADDR_WAKE);
        wr(WBWC_ADDR_WDOG, 8'hFF);
        wr(WBWC_ADDR_XCVR, 8'h06);
        wr(WBWC_ADDR_WAKE, 8'hFF);
        rlo = 2'($urandom);
        m_wd = (m_wd & 8'hB0) | 8'h04;
        m_xm = {5'h00, m_xm[2], rlo};
        m_wk = m_wk & 8'h40;
        pulse(6'h10);
        for (int i = 3; i < 7; i++) rd(7'(i));
        strap = 1'b1;
        repeat (4) @(negedge i_clk);
        m_wd = WBWC_WDOG_POR;
        m_xm = 8'h03;
        m_wk = 8'h00;
        pulse(6'h20);
        for (int i = 3; i < 7; i++) rd(7'(i));
        // mid-run power-on reset with strap high: mode comes from the late load
        wr(WBWC_ADDR_WDOG, 8'h60);
        wr(WBWC_ADDR_XCVR, 8'h05);
        i_rst_b = 1'b0;
        repeat (4) @(negedge i_clk);
        i_rst_b = 1'b1;
        m_wd = WBWC_WDOG_POR;
        m_xm = 8'h03;
        m_wk = WBWC_WAKE_POR;
        repeat (6) @(negedge i_clk);
        chk_cfg();
        for (int i = 3; i < 7; i++) rd(7'(i));
        give_verdict();
    end

    // about three times the expected run length
    initial begin
        repeat (80000) @(posedge i_clk);
        failures++;
        give_verdict();
    end
endmodule
